/* common/nbd_pkg.sv */
// Constants, field layout and event carrier for the network delay and diagnostics block.
// Assumes a single 200 MHz clock shared with every user of the package.
package nbd_pkg;
    // ********************************
    // Clock and timing
    // ********************************
    localparam int unsigned CLK_FREQ_HZ = 200_000_000;
    localparam int unsigned TICK_MS = 1;
    localparam int unsigned MS_CYCLES = CLK_FREQ_HZ / 1000 * TICK_MS;
    localparam int unsigned HB_PERIOD_S = 1;
    localparam int unsigned HB_TIMEOUT_MS = HB_PERIOD_S * 1000;
    localparam int unsigned RECHECK_S = 30;
    localparam int unsigned RECHECK_MS = RECHECK_S * 1000;
    // ********************************
    // Transmit delay limits in ms
    // ********************************
    localparam logic [7:0] DELAY_MIN = 8'h0A;
    localparam logic [7:0] DELAY_MAX = 8'hFF;
    // ********************************
    // Register offsets
    // ********************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DELAY = 8'h04;
    localparam logic [7:0] OFS_FLAGS = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    // ********************************
    // Flag layout, flag n sits at bit n-1
    // ********************************
    localparam int FLAG_W = 19;
    localparam int PEERS = 8;
    localparam int FB_RADIO = 8;
    localparam int FB_SYNC = 9;
    localparam int FB_ETH = 10;
    localparam int FB_ARITH = 11;
    localparam int FB_EXP = 12;
    localparam int FB_OVL = 13;
    localparam int FB_IRQOVL = 18;
    localparam logic [18:0] FLAG_RSV_MASK = 19'h3C000;
    localparam logic [3:0] GROUP_MIN_PEERS = 4'h2;
    // Control and status bits
    localparam int CB_RUN = 0;
    localparam int SB_BUSY = 0;
    localparam int SB_REJECT = 1;
    localparam int SB_OUT_OFF = 2;
    // ********************************
    // Event inputs from the controller
    // ********************************
    typedef struct packed {
        logic net_active;
        logic radio_enable;
        logic radio_signal;
        logic sync_fail;
        logic sync_ok;
        logic clock_set;
        logic eth_link_ok;
        logic st_program;
        logic arith_fault;
        logic expansion_lost;
        logic out_fault;
        logic irq_overrun;
    } nbd_evt_type;
endpackage : nbd_pkg

/* verilog/nbd_peer_watch.sv */
// Heartbeat watchdog for one peer station.
// Assumes heartbeat is a one-cycle pulse and ms_tick a one-cycle pulse each millisecond.
module nbd_peer_watch #(
    parameter int unsigned TIMEOUT_MS = nbd_pkg::HB_TIMEOUT_MS,
    parameter int CNT_W = 16
) (
    input wire logic clk, // Clock
    input wire logic resetn, // Async reset, active low
    input wire logic enable, // Watch is armed
    input wire logic ms_tick, // Millisecond tick
    input wire logic heartbeat, // Heartbeat seen from peer
    output logic missing // Peer absent
);
    localparam logic [CNT_W-1:0] LIMIT = CNT_W'(TIMEOUT_MS);
    logic [CNT_W-1:0] age_r;
    logic [CNT_W-1:0] age_nxt;
    logic missing_r;
    logic missing_nxt;
    wire expired = (age_r >= LIMIT);
    // Age counts milliseconds since the last heartbeat
    assign age_nxt = (!enable || heartbeat) ? '0 :
                     (ms_tick && !expired) ? age_r + 1'b1 : age_r;
    // Flag holds until the next heartbeat
    assign missing_nxt = enable && !heartbeat && (missing_r || expired);
    assign missing = missing_r;
    // Watchdog state
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            age_r <= '0;
            missing_r <= 1'b0;
        end
        else
        begin
            age_r <= age_nxt;
            missing_r <= missing_nxt;
        end
    end
endmodule : nbd_peer_watch

/* verilog/nbd_diag.sv */
// Network transmit hold-off and diagnostic flag bank with register port and interrupt.
// Assumes event inputs are synchronous to clk and the register master never overlaps strobes.
// Operation
// R1 - Delay register accepts only 10 to 255 ms
// R2 - Transmission waits the configured delay
// R3 - Software sizes delay with put/get formula
// R4 - Software sizes delay for markers only
// R5 - Flags live only in run mode
// R6 - Peer missing flag when group above two
// R7 - Radio time lost when enabled, no signal
// R8 - Failed time sync sets its flag
// R9 - Clock setting block leaves sync flag alone
// R10 - Ethernet failure sets its flag
// R11 - Structured text arithmetic fault sets flag
// R12 - Missing expansion module sets its flag
// R13 - Output overload switches off, rechecks later
// R14 - Interrupt overload sets its flag
// R15 - Peer flag holds until heartbeat returns
// R16 - Positions fifteen to eighteen read zero
//
// Added by the designer: the strobed register port and the placing of the registers.
module nbd_diag #(
    parameter int unsigned MS_CYCLES = nbd_pkg::MS_CYCLES,
    parameter int unsigned HB_TIMEOUT_MS = nbd_pkg::HB_TIMEOUT_MS,
    parameter int unsigned RECHECK_MS = nbd_pkg::RECHECK_MS
) (
    input wire logic clk, // Clock, 200 MHz
    input wire logic resetn, // Async reset, active low
    input wire logic [7:0] reg_addr, // Register byte address
    input wire logic [31:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [31:0] reg_rdata, // Read data, cycle after strobe
    input wire nbd_pkg::nbd_evt_type evt, // Controller events
    input wire logic [7:0] heartbeat, // Heartbeat pulse per peer
    input wire logic [3:0] station_count, // Stations in the group
    input wire logic tx_req, // Data ready to send
    output logic tx_go, // Send now pulse
    output logic tx_busy, // Hold-off running
    output logic [18:0] diag_flags, // Diagnostic flags
    output logic outputs_off, // Transistor outputs forced off
    output logic irq // Interrupt, active high level
);
    // ********************************
    // Declarations
    // ********************************
    typedef enum logic [1:0] {
        OVL_OK = 2'h0,
        OVL_OFF = 2'h1,
        OVL_CHECK = 2'h3
    } nbd_ovl_type;
    typedef enum logic {
        TX_IDLE = 1'b0,
        TX_WAIT = 1'b1
    } nbd_tx_type;
    localparam logic [31:0] MS_LAST = 32'(MS_CYCLES - 1);
    localparam logic [15:0] RECHECK_LIMIT = 16'(RECHECK_MS);
    logic run_r;
    logic run_nxt;
    logic [7:0] delay_r;
    logic [7:0] delay_nxt;
    logic reject_r;
    logic reject_nxt;
    logic [18:0] flags_r;
    logic [18:0] flags_nxt;
    logic [18:0] irq_stat_r;
    logic [18:0] irq_stat_nxt;
    logic [18:0] irq_mask_r;
    logic [18:0] irq_mask_nxt;
    logic irq_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [31:0] tick_cnt_r;
    logic [31:0] tick_cnt_nxt;
    logic sync_r;
    logic sync_nxt;
    logic arith_r;
    logic arith_nxt;
    nbd_ovl_type ovl_r;
    nbd_ovl_type ovl_nxt;
    logic [15:0] ovl_ms_r;
    logic [15:0] ovl_ms_nxt;
    logic off_r;
    nbd_tx_type tx_r;
    nbd_tx_type tx_nxt;
    logic [31:0] tx_cyc_r;
    logic [31:0] tx_cyc_nxt;
    logic [7:0] tx_ms_r;
    logic [7:0] tx_ms_nxt;
    logic tx_go_r;
    logic tx_go_nxt;
    logic [7:0] peer_miss;

    // ********************************
    // Register decode
    // ********************************
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // Write and read selects
    wire wr_ctrl = reg_wr && hit(reg_addr, nbd_pkg::OFS_CTRL);
    wire wr_delay = reg_wr && hit(reg_addr, nbd_pkg::OFS_DELAY);
    wire wr_mask = reg_wr && hit(reg_addr, nbd_pkg::OFS_IRQ_MASK);
    wire rd_stat = reg_rd && hit(reg_addr, nbd_pkg::OFS_IRQ_STAT);
    wire [7:0] wr_val = reg_wdata[7:0];
    wire delay_ok = (reg_wdata[31:8] == 24'h000000) && (wr_val >= nbd_pkg::DELAY_MIN)
        && (wr_val <= nbd_pkg::DELAY_MAX);
    wire [31:0] status_word = {29'h00000000, off_r, reject_r, tx_busy};

    // Control and delay registers
    assign run_nxt = wr_ctrl ? reg_wdata[nbd_pkg::CB_RUN] : run_r;
    assign delay_nxt = (wr_delay && delay_ok) ? wr_val : delay_r; // R1
    assign reject_nxt = wr_delay ? !delay_ok : reject_r; // R1
    assign irq_mask_nxt = wr_mask ? reg_wdata[18:0] : irq_mask_r;

    // Read multiplexer, unmapped reads return zero
    assign rdata_nxt = !reg_rd ? 32'h00000000 :
        hit(reg_addr, nbd_pkg::OFS_CTRL) ? {31'h00000000, run_r} :
        hit(reg_addr, nbd_pkg::OFS_DELAY) ? {24'h000000, delay_r} :
        hit(reg_addr, nbd_pkg::OFS_FLAGS) ? {13'h0000, flags_r} :
        hit(reg_addr, nbd_pkg::OFS_IRQ_STAT) ? {13'h0000, irq_stat_r} :
        hit(reg_addr, nbd_pkg::OFS_IRQ_MASK) ? {13'h0000, irq_mask_r} :
        hit(reg_addr, nbd_pkg::OFS_STATUS) ? status_word : 32'h00000000;

    // ********************************
    // Millisecond tick and peer watch
    // ********************************
    wire ms_tick = (tick_cnt_r == MS_LAST);
    assign tick_cnt_nxt = ms_tick ? 32'h00000000 : tick_cnt_r + 32'h00000001;
    wire peer_en = run_r && evt.net_active && (station_count > nbd_pkg::GROUP_MIN_PEERS);

    // One watchdog per peer station
    genvar gi;
    generate
        for (gi = 0; gi < nbd_pkg::PEERS; gi++)
        begin : g_peer
            nbd_peer_watch #(
                .TIMEOUT_MS(HB_TIMEOUT_MS),
                .CNT_W(16)
            ) u_watch (
                .clk(clk), // Clock
                .resetn(resetn), // Reset
                .enable(peer_en), // R6
                .ms_tick(ms_tick), // Tick
                .heartbeat(heartbeat[gi]), // R15
                .missing(peer_miss[gi]) // Absent
            );
        end
    endgenerate

    // ********************************
    // Diagnostic flags
    // ********************************
    // Time sync flag, set wins over clear; clock_set is deliberately not a term
    assign sync_nxt = run_r && (evt.sync_fail || (sync_r && !evt.sync_ok)); // R8 R9
    // Arithmetic fault latches while run lasts
    assign arith_nxt = run_r && (arith_r || (evt.st_program && evt.arith_fault)); // R11

    // Flag vector, cleared outside run
    always_comb
    begin
        flags_nxt = 19'h00000;
        flags_nxt[7:0] = peer_miss; // R6 R15
        flags_nxt[nbd_pkg::FB_RADIO] = evt.radio_enable && !evt.radio_signal; // R7
        flags_nxt[nbd_pkg::FB_SYNC] = sync_r; // R8
        flags_nxt[nbd_pkg::FB_ETH] = !evt.eth_link_ok; // R10
        flags_nxt[nbd_pkg::FB_ARITH] = arith_r; // R11
        flags_nxt[nbd_pkg::FB_EXP] = evt.expansion_lost; // R12
        flags_nxt[nbd_pkg::FB_OVL] = (ovl_r != OVL_OK); // R13
        flags_nxt[nbd_pkg::FB_IRQOVL] = evt.irq_overrun; // R14
        flags_nxt = flags_nxt & ~nbd_pkg::FLAG_RSV_MASK; // R16
        if (!run_r)
        begin
            flags_nxt = 19'h00000; // R5
        end
    end

    // ********************************
    // Output overload and recheck
    // ********************************
    wire recheck_due = (ovl_ms_r >= RECHECK_LIMIT);
    always_comb
    begin
        ovl_nxt = ovl_r;
        ovl_ms_nxt = ovl_ms_r;
        unique case (ovl_r)
            OVL_OK:
            begin
                ovl_ms_nxt = 16'h0000;
                if (evt.out_fault)
                begin
                    ovl_nxt = OVL_OFF; // R13
                end
            end
            OVL_OFF:
            begin
                if (recheck_due)
                begin
                    ovl_nxt = OVL_CHECK; // R13
                end
                else if (ms_tick)
                begin
                    ovl_ms_nxt = ovl_ms_r + 16'h0001;
                end
            end
            OVL_CHECK:
            begin
                ovl_ms_nxt = 16'h0000;
                ovl_nxt = evt.out_fault ? OVL_OFF : OVL_OK; // R13
            end
            default:
            begin
                ovl_nxt = OVL_OK;
            end
        endcase
        if (!run_r)
        begin
            ovl_nxt = OVL_OK;
            ovl_ms_nxt = 16'h0000;
        end
    end

    // ********************************
    // Transmit hold-off
    // ********************************
    wire tx_ms_end = (tx_cyc_r == MS_LAST);
    wire tx_done = tx_ms_end && (tx_ms_r == 8'h01);
    always_comb
    begin
        tx_nxt = tx_r;
        tx_cyc_nxt = tx_cyc_r;
        tx_ms_nxt = tx_ms_r;
        tx_go_nxt = 1'b0;
        unique case (tx_r)
            TX_IDLE:
            begin
                if (tx_req && run_r)
                begin
                    tx_nxt = TX_WAIT; // R2
                    tx_cyc_nxt = 32'h00000000;
                    tx_ms_nxt = delay_r;
                end
            end
            TX_WAIT:
            begin
                tx_cyc_nxt = tx_ms_end ? 32'h00000000 : tx_cyc_r + 32'h00000001;
                if (tx_ms_end)
                begin
                    tx_ms_nxt = tx_ms_r - 8'h01;
                end
                if (tx_done)
                begin
                    tx_nxt = TX_IDLE; // R2
                    tx_go_nxt = 1'b1;
                end
            end
        endcase
        if (!run_r)
        begin
            tx_nxt = TX_IDLE;
            tx_go_nxt = 1'b0;
        end
    end

    // ********************************
    // Interrupt status and output
    // ********************************
    wire [18:0] rise = flags_nxt & ~flags_r;
    assign irq_stat_nxt = (rd_stat ? 19'h00000 : irq_stat_r) | rise;

    // ********************************
    // Registers
    // ********************************
    // Software visible state
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            run_r <= 1'b0;
            delay_r <= nbd_pkg::DELAY_MIN;
            reject_r <= 1'b0;
            irq_mask_r <= 19'h00000;
            irq_stat_r <= 19'h00000;
            irq_r <= 1'b0;
            rdata_r <= 32'h00000000;
        end
        else
        begin
            run_r <= run_nxt;
            delay_r <= delay_nxt;
            reject_r <= reject_nxt;
            irq_mask_r <= irq_mask_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_r <= |(irq_stat_nxt & irq_mask_nxt);
            rdata_r <= rdata_nxt;
        end
    end

    // Flags and overload state
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            flags_r <= 19'h00000;
            sync_r <= 1'b0;
            arith_r <= 1'b0;
            ovl_r <= OVL_OK;
            ovl_ms_r <= 16'h0000;
            off_r <= 1'b0;
            tick_cnt_r <= 32'h00000000;
        end
        else
        begin
            flags_r <= flags_nxt;
            sync_r <= sync_nxt;
            arith_r <= arith_nxt;
            ovl_r <= ovl_nxt;
            ovl_ms_r <= ovl_ms_nxt;
            off_r <= (ovl_nxt == OVL_OFF); // R13
            tick_cnt_r <= tick_cnt_nxt;
        end
    end

    // Transmit state
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tx_r <= TX_IDLE;
            tx_cyc_r <= 32'h00000000;
            tx_ms_r <= 8'h00;
            tx_go_r <= 1'b0;
        end
        else
        begin
            tx_r <= tx_nxt;
            tx_cyc_r <= tx_cyc_nxt;
            tx_ms_r <= tx_ms_nxt;
            tx_go_r <= tx_go_nxt;
        end
    end

    // Outputs
    assign reg_rdata = rdata_r;
    assign tx_go = tx_go_r;
    assign tx_busy = (tx_r == TX_WAIT);
    assign diag_flags = flags_r;
    assign outputs_off = off_r;
    assign irq = irq_r;

    // ********************************
    // Assertions
    // ********************************
    property p_delay_range;
        @(posedge clk) disable iff (!resetn)
        delay_r >= nbd_pkg::DELAY_MIN;
    endproperty
    a_delay_range: assert property (p_delay_range) else $error("delay below minimum"); // R1

    property p_delay_reject;
        @(posedge clk) disable iff (!resetn)
        (wr_delay && !delay_ok) |=> ($stable(delay_r) && reject_r);
    endproperty
    a_delay_reject: assert property (p_delay_reject) else $error("bad delay taken"); // R1

    property p_tx_wait;
        @(posedge clk) disable iff (!resetn)
        tx_go |-> ($past(tx_ms_r) == 8'h01 && $past(tx_cyc_r) == MS_LAST);
    endproperty
    a_tx_wait: assert property (p_tx_wait) else $error("send before delay"); // R2

    property p_stop_clear;
        @(posedge clk) disable iff (!resetn)
        !run_r |=> (diag_flags == 19'h00000);
    endproperty
    a_stop_clear: assert property (p_stop_clear) else $error("flag outside run"); // R5

    property p_peer_gate;
        @(posedge clk) disable iff (!resetn)
        (diag_flags[7:0] != 8'h00) |-> $past(peer_en, 2);
    endproperty
    a_peer_gate: assert property (p_peer_gate) else $error("peer flag ungated"); // R6

    property p_radio;
        @(posedge clk) disable iff (!resetn)
        (run_r && evt.radio_enable && !evt.radio_signal) |=> diag_flags[nbd_pkg::FB_RADIO];
    endproperty
    a_radio: assert property (p_radio) else $error("radio flag missed"); // R7

    property p_sync_fail;
        @(posedge clk) disable iff (!resetn)
        (run_r && evt.sync_fail) ##1 run_r |=> diag_flags[nbd_pkg::FB_SYNC];
    endproperty
    a_sync_fail: assert property (p_sync_fail) else $error("sync flag missed"); // R8

    property p_clock_set;
        @(posedge clk) disable iff (!resetn)
        (run_r && evt.clock_set && !evt.sync_fail && !evt.sync_ok) |=> $stable(sync_r);
    endproperty
    a_clock_set: assert property (p_clock_set) else $error("clock set moved flag"); // R9

    property p_eth;
        @(posedge clk) disable iff (!resetn)
        (run_r && !evt.eth_link_ok) |=> diag_flags[nbd_pkg::FB_ETH];
    endproperty
    a_eth: assert property (p_eth) else $error("ethernet flag missed"); // R10

    property p_ovl_off;
        @(posedge clk) disable iff (!resetn)
        (run_r && ovl_r == OVL_OK && evt.out_fault) |=> (outputs_off ##1 diag_flags[nbd_pkg::FB_OVL]);
    endproperty
    a_ovl_off: assert property (p_ovl_off) else $error("overload not handled"); // R13

    property p_reserved;
        @(posedge clk) disable iff (!resetn)
        (diag_flags & nbd_pkg::FLAG_RSV_MASK) == 19'h00000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved flag set"); // R16

    c_tx_go: cover property (@(posedge clk) disable iff (!resetn) tx_go);
    c_recheck: cover property (@(posedge clk) disable iff (!resetn) ovl_r == OVL_CHECK);
    c_irq: cover property (@(posedge clk) disable iff (!resetn) $rose(irq));
endmodule : nbd_diag

/* tb/nbd_peer_model.sv */
// Peer stations of the group, each sending a periodic heartbeat pulse.
// Assumes clk and resetn of the block under test; alive selects present peers.
module nbd_peer_model #(
    parameter int PERIOD = 8
) (
    input wire logic clk, // Clock
    input wire logic resetn, // Async reset, active low
    input wire logic [7:0] alive, // Peers present on the network
    output logic [7:0] heartbeat // One-cycle pulse per peer
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt_r;
    // Every present peer beats once per period, absent peers stay silent
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_r <= 0;
            heartbeat <= 8'h00;
        end
        else
        begin
            cnt_r <= (cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
            heartbeat <= (cnt_r == 0) ? alive : 8'h00;
        end
    end
endmodule : nbd_peer_model

/* tb/tb_top.sv */
// Self-checking bench for the transmit hold-off and diagnostic flag block.
// Assumes the block's assertions sit in its own files; peers come from nbd_peer_model.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // ********************************
    // Signals and instances
    // ********************************
    localparam int MS = 4;
    logic clk, resetn, reg_wr, reg_rd, tx_req, tx_go, tx_busy, outputs_off, irq;
    logic [7:0] reg_addr, heartbeat, alive;
    logic [31:0] reg_wdata, reg_rdata, rv;
    logic [3:0] station_count;
    logic [18:0] diag_flags;
    nbd_pkg::nbd_evt_type evt;
    int err_count, samples_checked;
    int n_low;
    int dl[4] = '{10, 14, 22, 255};
    nbd_diag #(.MS_CYCLES(MS), .HB_TIMEOUT_MS(3), .RECHECK_MS(2)) u_dut (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evt(evt),
        .heartbeat(heartbeat), .station_count(station_count), .tx_req(tx_req),
        .tx_go(tx_go), .tx_busy(tx_busy), .diag_flags(diag_flags),
        .outputs_off(outputs_off), .irq(irq));
    nbd_peer_model #(.PERIOD(8)) u_peers (
        .clk(clk), .resetn(resetn), .alive(alive), .heartbeat(heartbeat));
    // Clock at 200 MHz
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ********************************
    // Tasks
    // ********************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
    // Let a cause pass through the flag registers
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    task automatic fl(input logic [31:0] exp);
        settle(3);
        chk({13'h0, diag_flags}, exp);
    endtask : fl
    // Count edges from the taking edge to the send pulse
    task automatic tx_meas(input int d);
        int n;
        n = 0;
        @(posedge clk);
        tx_req <= 1'b1;
        @(posedge clk);
        tx_req <= 1'b0;
        #1;
        chk({31'h0, tx_busy}, 32'h1);
        while (tx_go !== 1'b1 && n < 2000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(32'(n), 32'(d * MS));
    endtask : tx_meas
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test
    // ********************************
    // Tests
    // ********************************
    initial
    begin
        {reg_wr, reg_rd, tx_req, reg_addr, reg_wdata, station_count} = '0;
        evt = '0;
        evt.eth_link_ok = 1'b1;
        evt.radio_signal = 1'b1;
        alive = 8'hFF;
        err_count = 0;
        samples_checked = 0;
        resetn = 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(nbd_pkg::OFS_DELAY, rv);
        chk(rv, 32'h0000000A);
        rd(8'h20, rv);
        chk(rv, 32'h0);
        // Out of range delays are refused
        wr(nbd_pkg::OFS_DELAY, 32'h9);
        rd(nbd_pkg::OFS_STATUS, rv);
        chk(rv, 32'h2);
        wr(nbd_pkg::OFS_DELAY, 32'h100);
        rd(nbd_pkg::OFS_DELAY, rv);
        chk(rv, 32'h0000000A);
        wr(nbd_pkg::OFS_CTRL, 32'h1);
        // Hold-off at the boundaries and at both sizing formulas for three stations
        dl[1] = (3 - 1) * 2 * 2 + 6;
        dl[2] = (3 - 1) * 4 * 2 + 6;
        foreach (dl[i])
        begin
            wr(nbd_pkg::OFS_DELAY, 32'(dl[i]));
            rd(nbd_pkg::OFS_DELAY, rv);
            chk(rv, 32'(dl[i]));
            tx_meas(dl[i]);
        end
        rd(nbd_pkg::OFS_STATUS, rv);
        chk(rv, 32'h0);
        // Interrupt from ethernet failure, cleared by the status read
        wr(nbd_pkg::OFS_IRQ_MASK, 32'h1 << nbd_pkg::FB_ETH);
        @(posedge clk) evt.eth_link_ok <= 1'b0;
        fl(32'h1 << nbd_pkg::FB_ETH);
        chk({31'h0, irq}, 32'h1);
        rd(nbd_pkg::OFS_IRQ_STAT, rv);
        chk(rv, 32'h1 << nbd_pkg::FB_ETH);
        settle(2);
        chk({31'h0, irq}, 32'h0);
        @(posedge clk) evt.eth_link_ok <= 1'b1;
        @(posedge clk) evt.radio_enable <= 1'b1;
        @(posedge clk) evt.radio_signal <= 1'b0;
        fl(32'h1 << nbd_pkg::FB_RADIO);
        chk({31'h0, irq}, 32'h0);
        @(posedge clk) evt.radio_signal <= 1'b1;
        // Sync flag set by failure, kept by the clock setting block, cleared by success
        @(posedge clk) evt.sync_fail <= 1'b1;
        @(posedge clk) evt.sync_fail <= 1'b0;
        fl(32'h1 << nbd_pkg::FB_SYNC);
        @(posedge clk) evt.clock_set <= 1'b1;
        @(posedge clk) evt.clock_set <= 1'b0;
        fl(32'h1 << nbd_pkg::FB_SYNC);
        @(posedge clk) evt.sync_ok <= 1'b1;
        @(posedge clk) evt.sync_ok <= 1'b0;
        fl(32'h0);
        // Arithmetic fault counts only for structured text
        @(posedge clk) evt.arith_fault <= 1'b1;
        @(posedge clk) evt.arith_fault <= 1'b0;
        fl(32'h0);
        evt.st_program <= 1'b1;
        @(posedge clk) evt.arith_fault <= 1'b1;
        @(posedge clk) evt.arith_fault <= 1'b0;
        fl(32'h1 << nbd_pkg::FB_ARITH);
        @(posedge clk) evt.expansion_lost <= 1'b1;
        evt.irq_overrun <= 1'b1;
        fl((32'h1 << nbd_pkg::FB_ARITH) | (32'h1 << nbd_pkg::FB_EXP)
            | (32'h1 << nbd_pkg::FB_IRQOVL));
        rd(nbd_pkg::OFS_FLAGS, rv);
        chk(rv & 32'h0003C000, 32'h0);
        // Leaving run mode clears every flag
        wr(nbd_pkg::OFS_CTRL, 32'h0);
        fl(32'h0);
        @(posedge clk) evt.st_program <= 1'b0;
        evt.expansion_lost <= 1'b0;
        evt.irq_overrun <= 1'b0;
        wr(nbd_pkg::OFS_CTRL, 32'h1);
        // Missing peer in a group of three, then its heartbeat returns
        @(posedge clk) evt.net_active <= 1'b1;
        station_count <= 4'h3;
        alive <= 8'hFB;
        fl(32'h0);
        settle(40);
        chk({13'h0, diag_flags}, 32'h4);
        @(posedge clk) alive <= 8'hFF;
        settle(20);
        chk({13'h0, diag_flags}, 32'h0);
        @(posedge clk) station_count <= 4'h2;
        alive <= 8'hFB;
        settle(40);
        chk({13'h0, diag_flags}, 32'h0);
        @(posedge clk) alive <= 8'hFF;
        // Output overload switches outputs off until a recheck finds it gone
        @(posedge clk) evt.out_fault <= 1'b1;
        fl(32'h1 << nbd_pkg::FB_OVL);
        chk({31'h0, outputs_off}, 32'h1);
        // Past the first recheck, outputs come free one cycle per recheck period
        settle(8);
        n_low = 0;
        repeat (24)
        begin
            settle(1);
            if (outputs_off !== 1'b1)
                n_low++;
        end
        chk(32'(n_low), 32'(24 / (2 * MS)));
        @(posedge clk) evt.out_fault <= 1'b0;
        settle(30);
        chk({13'h0, diag_flags}, 32'h0);
        chk({31'h0, outputs_off}, 32'h0);
        stop_test();
    end
    // Watchdog against a hang
    initial
    begin
        #200us;
        err_count++;
        stop_test();
    end
endmodule : tb_top
